// ---- src/panel_pin_pkg.sv ----
// Constants and carrier types for the flat-panel pin control block
package panel_pin_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_INPUT_ENABLE = 12'h60C;
    localparam logic [11:0] OFS_DITHER_MOD = 12'h610;
    localparam logic [11:0] OFS_POLARITY = 12'h614;
    localparam logic [11:0] OFS_INPUT_STATUS = 12'h624;
    localparam logic [11:0] OFS_TIMING = 12'h604;
    // Implemented pin masks; reserved bits hold zero
    localparam logic [31:0] INPUT_EN_MASK = 32'hFFFC_FCF8;
    localparam logic [31:0] POLARITY_MASK = 32'hFFFC_FCFC;
    localparam logic [31:0] TIMING_MASK = 32'h0040_0000;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam int MOD_LO = 24;
    localparam int MOD_W = 7;
    localparam int MOD_SRC_BIT = 31;
    localparam int MOD_FREQ_BIT = 22;
    localparam int SCLK_POL_BIT = 24;
    localparam int MOD_POL_BIT = 28;
    localparam int MOD_DELAY_CYC = 4;
    typedef struct packed {
        logic [7:0] tune2;
        logic [7:0] tune1;
        logic [7:0] tune0;
    } dither_tune_t;
    // Internal timing strobes handed in by the display pipeline
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic data_en;
    } sync_t;
endpackage

// ---- src/panel_mod_gen.sv ----
// Panel modulation signal generator
`timescale 1ns/1ps
module panel_mod_gen (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire panel_pin_pkg::sync_t sync,
    input wire logic [6:0] half_period,
    input wire logic src_hsync,
    input wire logic de_mode,
    output logic mod_out
);
    import panel_pin_pkg::*;
    logic hs_q, hs_d, vs_q, vs_d, pend_q, pend_d, mod_q, mod_d;
    logic [6:0] cnt_q, cnt_d;
    logic [2:0] dly_q, dly_d;
    logic hs_rise, tick, arm;
    assign hs_rise = sync.hsync & ~hs_q;
    assign tick = src_hsync ? hs_rise : (sync.vsync & ~vs_q);
    // In data-enable mode the period count is bypassed entirely
    assign arm = de_mode ? ~sync.data_en : (tick && (cnt_q >= half_period));
    assign mod_out = mod_q;
    // Count ticks, arm a toggle, then wait out the fixed hsync delay
    always_comb begin
        hs_d = sync.hsync;
        vs_d = sync.vsync;
        cnt_d = cnt_q;
        pend_d = pend_q;
        dly_d = dly_q;
        mod_d = mod_q;
        if (!de_mode && tick) begin
            if (cnt_q >= half_period) begin
                cnt_d = 7'h00;
            end else begin
                cnt_d = cnt_q + 7'h01;
            end
        end
        // An arm that lands on the firing hsync is used at once, never dropped
        if (hs_rise && (pend_q || arm)) begin
            dly_d = 3'(MOD_DELAY_CYC - 1);
            pend_d = 1'b0;
        end else begin
            pend_d = pend_q | arm;
            if (dly_q != 3'h0) begin
                dly_d = dly_q - 3'h1;
                if (dly_q == 3'h1) begin
                    mod_d = ~mod_q;
                end
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            cnt_q <= 7'h00;
            pend_q <= 1'b0;
            dly_q <= 3'h0;
            mod_q <= 1'b0;
        end else if (ce) begin
            hs_q <= hs_d;
            vs_q <= vs_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            dly_q <= dly_d;
            mod_q <= mod_d;
        end
    end
    // A toggle is fired by an hsync rise and lands after the fixed delay
    sequence fire_s;
        ce && hs_rise && (pend_q || arm) && dly_q == 3'h0;
    endsequence
    sequence wait_s;
        ce [*3];
    endsequence
    property mod_delay_p;
        @(posedge clk) disable iff (rst)
        fire_s ##1 wait_s |=> mod_q != $past(mod_q);
    endproperty
    mod_delay_a: assert property (mod_delay_p) else $error("modulation late");
    mod_steady_a: assert property (@(posedge clk) disable iff (rst)
        !(ce && dly_q == 3'h1) |=> $stable(mod_q)) else $error("modulation off grid");
    count_ignored_a: assert property (@(posedge clk) disable iff (rst)
        (ce && de_mode && sync.data_en && !pend_q) |=> !pend_q)
        else $error("count used in data enable mode");
endmodule

// ---- src/flat_panel_pin_control.sv ----
// Flat-panel pin control: registers, input readback, output polarity
`timescale 1ns/1ps
module flat_panel_pin_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [panel_pin_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire panel_pin_pkg::sync_t sync,
    input wire logic [31:0] pin_src,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_in_buf_en,
    output panel_pin_pkg::dither_tune_t dither_tune
);
    import panel_pin_pkg::*;
    logic [31:0] inen_q, inen_d, dmod_q, dmod_d, pol_q, pol_d, tim_q, tim_d;
    logic [31:0] rdata_q, rdata_d, s1_q, s2_q, stat;
    logic mod_sig;
    logic [31:0] src_mux;
    // Register write and read data
    always_comb begin
        inen_d = inen_q;
        dmod_d = dmod_q;
        pol_d = pol_q;
        tim_d = tim_q;
        rdata_d = 32'h0000_0000;
        if (wr) begin
            case (addr)
                OFS_INPUT_ENABLE: inen_d = wdata & INPUT_EN_MASK;
                OFS_DITHER_MOD: dmod_d = wdata;
                OFS_POLARITY: pol_d = wdata & POLARITY_MASK;
                OFS_TIMING: tim_d = wdata & TIMING_MASK;
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                OFS_INPUT_ENABLE: rdata_d = inen_q;
                OFS_DITHER_MOD: rdata_d = dmod_q;
                OFS_POLARITY: rdata_d = pol_q;
                OFS_TIMING: rdata_d = tim_q;
                OFS_INPUT_STATUS: rdata_d = stat;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inen_q <= RESET_VALUE;
            dmod_q <= RESET_VALUE;
            pol_q <= RESET_VALUE;
            tim_q <= RESET_VALUE;
            rdata_q <= RESET_VALUE;
        end else if (ce) begin
            inen_q <= inen_d;
            dmod_q <= dmod_d;
            pol_q <= pol_d;
            tim_q <= tim_d;
            rdata_q <= rdata_d;
        end
    end
    // Two-stage synchroniser on pin levels; only stage two is looked at
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 32'h0000_0000;
            s2_q <= 32'h0000_0000;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
        end
    end
    assign stat = s2_q & inen_q;
    assign pin_in_buf_en = inen_q;
    assign rdata = rdata_q;
    assign dither_tune = dmod_q[23:0];
    panel_mod_gen u_mod (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sync(sync),
        .half_period(dmod_q[MOD_LO +: MOD_W]),
        .src_hsync(dmod_q[MOD_SRC_BIT]),
        .de_mode(tim_q[MOD_FREQ_BIT]),
        .mod_out(mod_sig)
    );
    // Modulation replaces its pin source before polarity is applied
    always_comb begin
        src_mux = pin_src;
        src_mux[MOD_POL_BIT] = mod_sig;
    end
    // Polarity last; bit 24 inversion moves the data-change edge of the shift clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= 32'h0000_0000;
        end else if (ce) begin
            pin_out <= src_mux ^ pol_q;
        end
    end
    readback_gate_a: assert property (@(posedge clk) disable iff (rst)
        (ce && rd && addr == OFS_INPUT_STATUS) |=> (rdata & ~$past(inen_q)) == 32'h0)
        else $error("disabled pin visible");
    write_enable_a: assert property (@(posedge clk) disable iff (rst)
        (ce && wr && addr == OFS_INPUT_ENABLE) |=>
        pin_in_buf_en == ($past(wdata) & INPUT_EN_MASK))
        else $error("input enable write lost");
    polarity_out_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> pin_out == ($past(src_mux) ^ $past(pol_q))) else $error("bad polarity");
    read_data_a: assert property (@(posedge clk) disable iff (rst)
        (ce && rd && addr == OFS_POLARITY) |=> rdata == $past(pol_q)) else $error("bad read");
endmodule

// ---- verif/panel_model.sv ----
// Behavioural panel that drives levels back onto the shared pins
`timescale 1ns/1ps
module panel_model (
    input wire logic clk,
    input wire logic [31:0] pin_out,
    input wire logic drive,
    input wire logic [31:0] drive_val,
    output logic [31:0] pin_in
);
    initial pin_in = '0;
    // Released pins toggle every clock where pin_out is low and hold their level where pin_out is high
    always @(posedge clk) begin
        pin_in <= drive ? drive_val : ~pin_in ^ pin_out;
    end
endmodule

// ---- verif/test_flat_panel_pin_control.sv ----
// Self-checking bench for the flat-panel pin control block
`timescale 1ns/1ps
module test_flat_panel_pin_control;
    import panel_pin_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, drive = 0, hs_prev = 0, mod_prev = 0, watch = 0;
    logic ce = 1'b1;
    logic [11:0] addr = '0;
    logic [31:0] wdata = '0, pin_src = '0, drive_val = '0, rdata, pin_out, pin_in, buf_en, got;
    sync_t sync = '0;
    dither_tune_t tune;
    int error_cnt = 0, tests_run = 0, cyc = 0, hs_cnt = 0, toggles = 0;
    always #12.5 clk = ~clk;
    flat_panel_pin_control i_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sync(sync), .pin_src(pin_src), .pin_in(pin_in),
        .pin_out(pin_out), .pin_in_buf_en(buf_en), .dither_tune(tune));
    panel_model i_panel (.clk(clk), .pin_out(pin_out), .drive(drive), .drive_val(drive_val),
        .pin_in(pin_in));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each bus task starts just after a rising edge and leaves one edge idle
    task automatic reg_wr(logic [11:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_rd(logic [11:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic t_regs();
        reg_rd(OFS_INPUT_ENABLE, got);
        check("enable reset", RESET_VALUE, got);
        reg_wr(OFS_INPUT_ENABLE, 32'hFFFF_FFFF);
        reg_rd(OFS_INPUT_ENABLE, got);
        check("enable mask", INPUT_EN_MASK, got);
        check("buffer enables", INPUT_EN_MASK, buf_en);
        reg_wr(OFS_DITHER_MOD, 32'h00A5_5A3C);
        check("dither tune", 32'h00A5_5A3C, {8'h00, tune});
        reg_wr(OFS_POLARITY, 32'hFFFF_FFFF);
        reg_rd(OFS_POLARITY, got);
        check("polarity mask", POLARITY_MASK, got);
        reg_rd(12'h700, got);
        check("unmapped read", 32'h0000_0000, got);
    endtask
    // Control pins 24-31 and data pins share one status word
    task automatic t_readback();
        reg_wr(OFS_INPUT_ENABLE, 32'hF0F8_3CB8);
        drive <= 1'b1;
        drive_val <= 32'hA5A5_5A5A;
        repeat (4) @(posedge clk);
        reg_rd(OFS_INPUT_STATUS, got);
        check("status", 32'hA5A5_5A5A & 32'hF0F8_3CB8, got);
        drive <= 1'b0;
    endtask
    // Shift clock bit 24 inverted too; then a frozen clock enable must hold the pins
    task automatic t_polarity();
        reg_wr(OFS_POLARITY, 32'h0100_C0F4);
        pin_src <= 32'h0000_3C3C;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("pin out", 32'h0100_FCC8, pin_out & 32'hEFFF_FFFF);
        @(posedge clk);
        ce <= 1'b0;
        pin_src <= 32'h0000_0000;
        repeat (3) @(negedge clk);
        check("frozen pins", 32'h0100_FCC8, pin_out & 32'hEFFF_FFFF);
        @(posedge clk);
        ce <= 1'b1;
    endtask
    // n lines per call, each an hsync pulse, optional vsync pulse beside it, 20 clocks
    task automatic lines(int n, logic v);
        repeat (n) begin
            sync.hsync <= 1'b1;
            sync.vsync <= v;
            @(posedge clk);
            sync.hsync <= 1'b0;
            sync.vsync <= 1'b0;
            repeat (19) @(posedge clk);
        end
    endtask
    task automatic t_mod();
        reg_wr(OFS_POLARITY, 32'h0000_0000);
        reg_wr(OFS_DITHER_MOD, 32'h8000_0000);
        watch <= 1'b1;
        lines(12, 1'b0);
        check("hsync toggles", 32'h0000_000C, 32'(toggles));
        reg_wr(OFS_DITHER_MOD, 32'h0000_0000);
        lines(2, 1'b0);
        toggles = 0;
        lines(6, 1'b0);
        check("vsync source", 32'h0, 32'(toggles));
        reg_wr(OFS_DITHER_MOD, 32'h0100_0000);
        toggles = 0;
        lines(6, 1'b1);
        check("half period", 32'h0000_0003, 32'(toggles));
        reg_wr(OFS_DITHER_MOD, 32'h8000_0000);
        sync.data_en <= 1'b1;
        reg_wr(OFS_TIMING, 32'h0040_0000);
        toggles = 0;
        lines(4, 1'b0);
        check("count ignored", 32'h0, 32'(toggles));
        sync.data_en <= 1'b0;
        lines(4, 1'b0);
        check("data enable low", 32'h0000_0004, 32'(toggles));
    endtask
    // Toggle position measured from the hsync rise, plus the output register
    always @(negedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            report_and_stop();
        end
        hs_cnt = (sync.hsync && !hs_prev) ? 0 : hs_cnt + 1;
        hs_prev = sync.hsync;
        if (watch && pin_out[28] !== mod_prev) begin
            toggles++;
            check("mod delay", 32'(MOD_DELAY_CYC + 1), 32'(hs_cnt));
        end
        mod_prev = pin_out[28];
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_readback();
        t_polarity();
        t_mod();
        report_and_stop();
    end
endmodule
